// File: delim_params.svh
// Constants for the delimiter select and detect block: register offsets,
// reset values and widths. Included by the package users; holds definitions only.
`ifndef DELIM_PARAMS_SVH
`define DELIM_PARAMS_SVH
`define DELIM_A_BYTE1_ADDR 8'h3a
`define DELIM_A_BYTE2_ADDR 8'h3b
`define DELIM_A_BYTE3_ADDR 8'h3c
`define DELIM_A_BYTE4_ADDR 8'h3d
`define DELIM_B_BYTE1_ADDR 8'h3e
`define DELIM_B_BYTE2_ADDR 8'h3f
`define DELIM_B_BYTE3_ADDR 8'h40
`define DELIM_B_BYTE4_ADDR 8'h41
`define DELIM_BYTE_RESET 8'ha7
`define DELIM_SHORT_MAX 3'h2
`define DELIM_HALF_BITS 16
`define DELIM_FULL_BITS 32
`endif

// File: delim_pkg.sv
// Types shared by the delimiter select and detect block.
// Assumes the constants header is included by the files that need numbers.
package delim_pkg;
  typedef enum logic [1:0] {
    TX_IDLE,
    TX_SEND
  } tx_state_t;
  typedef enum logic [1:0] {
    MATCH_NONE,
    MATCH_UNCODED,
    MATCH_CODED
  } match_kind_t;
endpackage : delim_pkg

// File: delim_matcher.sv
// Bit-serial delimiter comparator: shifts received bits and compares the
// window against one uncoded and one coded pattern of the chosen length.
// Assumes rx_bit_valid_i is a one-cycle strobe from logic on clk_i.
`timescale 1ns/1ps
`include "delim_params.svh"
module delim_matcher (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_i,
  // Received bit stream.
  input wire logic rx_bit_i,
  input wire logic rx_bit_valid_i,
  input wire logic search_en_i,
  // Patterns and compare width in bits.
  input wire logic [31:0] uncoded_i,
  input wire logic [31:0] coded_i,
  input wire logic coded_en_i,
  input wire logic [5:0] nbits_i,
  // Results, combinational from the shift register.
  output logic uncoded_hit_o,
  output logic coded_hit_o
);
  logic [31:0] shift_q;
  logic [31:0] mask_w;
  logic [5:0] count_q;
  logic full_w;

  // Mask selects the newest nbits received bits.
  assign mask_w = (nbits_i >= 6'd32) ? 32'hffff_ffff : ((32'h1 << nbits_i) - 32'h1);
  assign full_w = (count_q >= nbits_i);
  // Compare on every bit once the window holds enough bits.
  assign uncoded_hit_o = rx_bit_valid_i & search_en_i & full_w &
                         (((shift_q ^ uncoded_i) & mask_w) == 32'h0);
  assign coded_hit_o = rx_bit_valid_i & search_en_i & full_w & coded_en_i &
                       (((shift_q ^ coded_i) & mask_w) == 32'h0);

  // The shift register is compared on the next bit strobe after the newest bit lands.
  always_ff @(posedge clk_i) begin
    if (reset_i || !search_en_i) begin
      shift_q <= 32'h0;
      count_q <= 6'h0;
    end else if (rx_bit_valid_i) begin
      shift_q <= {shift_q[30:0], rx_bit_i};
      if (count_q != 6'd32) count_q <= count_q + 6'd1;
    end
  end
endmodule : delim_matcher

// File: delim_select.sv
// Delimiter select and detect top: byte register port, transmit shifter and
// receive search. Assumes a register port on clk_i and bit strobes on clk_i.
`timescale 1ns/1ps
`include "delim_params.svh"
module delim_select (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_i,
  // Byte register port.
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Configuration bits.
  input wire logic delim_group_select_i,
  input wire logic fec_enable_bit_i,
  input wire logic [2:0] delim_len_i,
  input wire logic channel_assess_done_i,
  // Transmit side.
  input wire logic preamble_done_i,
  input wire logic tx_bit_req_i,
  output logic tx_bit_o,
  output logic tx_active_o,
  // Receive side.
  input wire logic rx_search_i,
  input wire logic rx_bit_i,
  input wire logic rx_bit_valid_i,
  output logic delim_detect_o,
  output logic fec_decode_o
);
  logic [7:0] pat_a_q [4];
  logic [7:0] pat_b_q [4];
  logic [31:0] pat_a_w;
  logic [31:0] pat_b_w;
  logic [31:0] sel_w;
  logic short_w;
  logic [5:0] nbits_w;
  logic [31:0] tx_word_w;
  logic [31:0] uncoded_w;
  logic [31:0] coded_w;
  logic dual_w;
  logic uncoded_hit_w;
  logic coded_hit_w;
  logic [7:0] rdata_w;
  delim_pkg::tx_state_t tx_state_q;
  logic [31:0] tx_shift_q;
  logic [5:0] tx_left_q;
  logic tx_bit_q;
  logic tx_active_q;
  logic detect_q;
  logic fec_q;
  logic [7:0] rdata_q;
  logic [2:0] len_w;

  // Byte registers: one generate loop for the four bytes of each pattern.
  for (genvar i = 0; i < 4; i++) begin : g_byte
    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        pat_a_q[i] <= `DELIM_BYTE_RESET;
        pat_b_q[i] <= `DELIM_BYTE_RESET;
      end else if (reg_wr_i) begin
        if (reg_addr_i == `DELIM_A_BYTE1_ADDR + 8'(i)) pat_a_q[i] <= reg_wdata_i;
        if (reg_addr_i == `DELIM_B_BYTE1_ADDR + 8'(i)) pat_b_q[i] <= reg_wdata_i;
      end
    end
  end

  // Byte 1 is the first byte on air in a four-byte or coded two-byte delimiter, so it is the most significant byte.
  assign pat_a_w = {pat_a_q[0], pat_a_q[1], pat_a_q[2], pat_a_q[3]};
  assign pat_b_w = {pat_b_q[0], pat_b_q[1], pat_b_q[2], pat_b_q[3]};
  assign sel_w = delim_group_select_i ? pat_b_w : pat_a_w;

  // Length is clamped to 1..4 bytes; zero acts as one byte.
  assign len_w = (delim_len_i == 3'h0) ? 3'h1 : ((delim_len_i > 3'h4) ? 3'h4 : delim_len_i);
  assign short_w = (len_w <= `DELIM_SHORT_MAX);
  assign nbits_w = {len_w, 3'h0};

  // Transmit word: half selected by FEC for short, full word for long.
  assign tx_word_w = !short_w ? sel_w :
                     (fec_enable_bit_i ? {16'h0, sel_w[31:16]} : {16'h0, sel_w[15:0]});

  // Receive patterns: dual search only for short delimiter with FEC on.
  assign dual_w = short_w & fec_enable_bit_i;
  assign uncoded_w = short_w ? {16'h0, sel_w[15:0]} : sel_w;
  assign coded_w = {16'h0, sel_w[31:16]};

  // Register read mux; unmapped addresses read as zero.
  assign rdata_w = (reg_addr_i >= `DELIM_A_BYTE1_ADDR && reg_addr_i <= `DELIM_A_BYTE4_ADDR) ?
                   pat_a_q[2'(reg_addr_i - `DELIM_A_BYTE1_ADDR)] :
                   (reg_addr_i >= `DELIM_B_BYTE1_ADDR && reg_addr_i <= `DELIM_B_BYTE4_ADDR) ?
                   pat_b_q[2'(reg_addr_i - `DELIM_B_BYTE1_ADDR)] : 8'h0;

  // Read data is registered so the port comes straight from a flip-flop.
  always_ff @(posedge clk_i) begin
    if (reset_i) rdata_q <= 8'h0;
    else rdata_q <= rdata_w;
  end

  // Transmit shifter, loaded right after the preamble, MSB first.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tx_state_q <= delim_pkg::TX_IDLE;
      tx_shift_q <= 32'h0;
      tx_left_q <= 6'h0;
      tx_bit_q <= 1'b0;
      tx_active_q <= 1'b0;
    end else begin
      unique case (tx_state_q)
        delim_pkg::TX_IDLE: begin
          tx_active_q <= 1'b0;
          if (preamble_done_i) begin
            tx_shift_q <= tx_word_w << (6'd32 - nbits_w);
            tx_left_q <= nbits_w;
            tx_active_q <= 1'b1;
            tx_state_q <= delim_pkg::TX_SEND;
          end
        end
        delim_pkg::TX_SEND: begin
          if (tx_bit_req_i) begin
            tx_bit_q <= tx_shift_q[31];
            tx_shift_q <= {tx_shift_q[30:0], 1'b0};
            tx_left_q <= tx_left_q - 6'd1;
            if (tx_left_q == 6'd1) begin
              tx_active_q <= 1'b0;
              tx_state_q <= delim_pkg::TX_IDLE;
            end
          end
        end
        default: tx_state_q <= delim_pkg::TX_IDLE;
      endcase
    end
  end

  // The matcher reports a window one strobe after its last bit arrives; the
  // sender must follow the delimiter with at least one more bit strobe.
  delim_matcher u_matcher (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .rx_bit_i(rx_bit_i),
    .rx_bit_valid_i(rx_bit_valid_i),
    .search_en_i(rx_search_i),
    .uncoded_i(uncoded_w),
    .coded_i(coded_w),
    .coded_en_i(dual_w),
    .nbits_i(nbits_w),
    .uncoded_hit_o(uncoded_hit_w),
    .coded_hit_o(coded_hit_w)
  );

  // Detect pulse is independent of the assessment-done flag, which is only
  // observed, never used to gate reception. Coded match wins a tie.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      detect_q <= 1'b0;
      fec_q <= 1'b0;
    end else begin
      detect_q <= uncoded_hit_w | coded_hit_w;
      if (coded_hit_w) fec_q <= 1'b1;
      else if (uncoded_hit_w) fec_q <= 1'b0;
    end
  end

  // Every output is a plain copy of a register, with no logic after it.
  assign reg_rdata_o = rdata_q;
  assign tx_bit_o = tx_bit_q;
  assign tx_active_o = tx_active_q;
  assign delim_detect_o = detect_q;
  assign fec_decode_o = fec_q;

  // Assertions. The detect and flag checks watch the registered results, so a broken gate in the
  // matcher or the flag logic shows up here rather than only at the pins.
  a_det_coded_a: assert property (@(posedge clk_i) disable iff (reset_i)
    coded_hit_w |=> delim_detect_o && fec_decode_o) else $error("coded hit lost");
  a_det_unc_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (uncoded_hit_w && !coded_hit_w) |=> delim_detect_o && !fec_decode_o)
    else $error("uncoded hit wrong");
  a_single_nofec_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (!dual_w && (uncoded_hit_w || coded_hit_w)) |=> !fec_decode_o)
    else $error("coded search when single");
  a_detect_cca_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (uncoded_hit_w && !channel_assess_done_i) |=> delim_detect_o)
    else $error("detect gated by assessment");
  a_sel_group_a: assert property (@(posedge clk_i) disable iff (reset_i)
    delim_group_select_i |-> sel_w == pat_b_w) else $error("group select wrong");
  a_tx_long_a: assert property (@(posedge clk_i) disable iff (reset_i)
    !short_w |-> tx_word_w == sel_w) else $error("long word wrong");
  a_tx_short_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (short_w && fec_enable_bit_i) |-> tx_word_w[15:0] == sel_w[31:16])
    else $error("short coded half wrong");
  a_reset_val_a: assert property (@(posedge clk_i)
    (!reset_i && $past(reset_i)) |->
    pat_a_w == {4{`DELIM_BYTE_RESET}} && pat_b_w == {4{`DELIM_BYTE_RESET}})
    else $error("reset pattern wrong");
  a_write_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (reg_wr_i && reg_addr_i == `DELIM_A_BYTE4_ADDR) |=> pat_a_w[7:0] == $past(reg_wdata_i))
    else $error("byte write lost");
  a_tx_start_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (tx_state_q == delim_pkg::TX_IDLE && preamble_done_i) |=> tx_active_o)
    else $error("tx not started");
  a_tx_end_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (tx_state_q == delim_pkg::TX_SEND && tx_bit_req_i && tx_left_q == 6'd1) |=>
    !tx_active_o && tx_state_q == delim_pkg::TX_IDLE) else $error("tx not ended");
  a_fec_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
    !(uncoded_hit_w || coded_hit_w) |=> $stable(fec_decode_o))
    else $error("fec flag moved without match");
  a_rdata_zero_a: assert property (@(posedge clk_i) disable iff (reset_i)
    !(reg_addr_i inside {[`DELIM_A_BYTE1_ADDR:`DELIM_B_BYTE4_ADDR]}) |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  c_coded_c: cover property (@(posedge clk_i) coded_hit_w);
  c_uncoded_c: cover property (@(posedge clk_i) uncoded_hit_w && dual_w);
  c_long_c: cover property (@(posedge clk_i) uncoded_hit_w && !short_w);
  c_tx_c: cover property (@(posedge clk_i) tx_active_o ##1 !tx_active_o);
  c_long_fec_c: cover property (@(posedge clk_i) uncoded_hit_w && !short_w && fec_enable_bit_i);
endmodule : delim_select

// File: remote_radio.sv
// Remote radio model: sends a delimiter bit stream, most significant bit first.
// Assumes the bench calls send between frames on the same clock as the block.
`timescale 1ns/1ps
module remote_radio (
  // Clock.
  input wire logic clk_i,
  // Bit stream toward the receiver.
  output logic rx_bit_o,
  output logic rx_bit_valid_o
);
  // Line idles low before the first frame.
  initial begin
    rx_bit_o = 1'b0;
    rx_bit_valid_o = 1'b0;
  end
  // One strobe per bit plus a trailing strobe, since the block compares the
  // window before the strobed bit enters.
  task automatic send(input logic [31:0] word, input int nbits);
    for (int i = nbits; i >= 0; i--) begin
      @(negedge clk_i);
      rx_bit_o = (i > 0) ? word[i - 1] : ~rx_bit_o;
      rx_bit_valid_o = 1'b1;
      @(negedge clk_i);
      rx_bit_valid_o = 1'b0;
      rx_bit_o = ~rx_bit_o; // Idle line never repeats a stale bit.
    end
  endtask : send
endmodule : remote_radio

// File: testbench.sv
// Self-checking bench for the delimiter select block.
// Assumes the remote radio model feeds the receive bit stream.
`timescale 1ns/1ps
`include "delim_params.svh"
module testbench;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic sel = 1'b0;
  logic fec = 1'b0;
  logic [2:0] len = 3'h2;
  logic pre = 1'b0;
  logic req = 1'b0;
  logic search = 1'b0;
  logic done = 1'b0;
  logic rx_bit, rx_valid, tx_bit_o, tx_active_o, delim_detect_o, fec_decode_o;
  logic [7:0] reg_rdata_o;
  int mismatches = 0;
  int n_tests = 0;
  int n_det = 0;
  logic [31:0] pat [2] = '{32'h0972f672, 32'h5e70c6b4};
  logic [7:0] rec [8] = '{8'h09, 8'h72, 8'hf6, 8'h72, 8'h5e, 8'h70, 8'hc6, 8'hb4};
  // Device under test and the far-side radio.
  delim_select u_dut (.clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .delim_group_select_i(sel), .fec_enable_bit_i(fec), .delim_len_i(len),
    .channel_assess_done_i(done), .preamble_done_i(pre), .tx_bit_req_i(req),
    .tx_bit_o(tx_bit_o), .tx_active_o(tx_active_o), .rx_search_i(search),
    .rx_bit_i(rx_bit), .rx_bit_valid_i(rx_valid), .delim_detect_o(delim_detect_o),
    .fec_decode_o(fec_decode_o));
  remote_radio u_radio (.clk_i(clk_i), .rx_bit_o(rx_bit), .rx_bit_valid_o(rx_valid));
  // Clock and detection pulse counter, sampled at the falling edge where it has settled.
  always #2.5 clk_i = ~clk_i;
  always @(negedge clk_i) if (delim_detect_o === 1'b1) n_det++;
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_i);
    reg_addr_i = a;
    repeat (2) @(negedge clk_i);
    check(reg_rdata_o, e, "register read");
  endtask : reg_read
  // Reset values, then an unmapped place that must stay zero.
  task automatic reset_scenario();
    for (int i = 0; i < 8; i++) reg_read(8'h3a + 8'(i), `DELIM_BYTE_RESET);
    reg_write(8'h42, 8'h55);
    reg_read(8'h42, 8'h00);
  endtask : reset_scenario
  task automatic load_scenario();
    for (int i = 0; i < 8; i++) reg_write(8'h3a + 8'(i), rec[i]);
    for (int i = 0; i < 8; i++) reg_read(8'h3a + 8'(i), rec[i]);
  endtask : load_scenario
  task automatic tx_case(input logic s, input logic f, input logic [2:0] l);
    logic [31:0] w;
    int e;
    e = (l == 3'h0) ? 1 : ((l > 3'h4) ? 4 : int'(l));
    w = (e > 2) ? pat[s] : {16'h0000, f ? pat[s][31:16] : pat[s][15:0]};
    @(negedge clk_i);
    sel = s;
    fec = f;
    len = l;
    pre = 1'b1;
    @(negedge clk_i);
    pre = 1'b0;
    check(tx_active_o, 1'b1, "tx active");
    for (int i = 8 * e - 1; i >= 0; i--) begin
      req = 1'b1;
      @(negedge clk_i);
      req = 1'b0;
      check(tx_bit_o, w[i], "tx bit");
      @(negedge clk_i);
    end
    check(tx_active_o, 1'b0, "tx done");
  endtask : tx_case
  // Every select, coding and length 1 to 4 combination on transmit, then lengths 0 and 7 once each.
  task automatic tx_scenario();
    for (int k = 0; k < 16; k++) tx_case(k[0], k[1], 3'(k / 4 + 1));
    tx_case(1'b1, 1'b0, 3'h0);
    tx_case(1'b0, 1'b1, 3'h7);
  endtask : tx_scenario
  task automatic rx_case(input logic s, input logic f, input logic [2:0] l,
      input logic [31:0] w, input logic d, input logic c);
    @(negedge clk_i);
    sel = s;
    fec = f;
    len = l;
    search = 1'b1;
    n_det = 0;
    u_radio.send(w, 8 * l);
    repeat (3) @(negedge clk_i);
    check(n_det, d, "detect count");
    if (d) check(fec_decode_o, c, "fec decode");
    search = 1'b0;
  endtask : rx_case
  // Assessment stays pending in every case but the fourth, yet matches must still be reported.
  task automatic rx_scenario();
    rx_case(1'b0, 1'b1, 3'h2, pat[0] >> 16, 1'b1, 1'b1);
    rx_case(1'b1, 1'b1, 3'h1, pat[1], 1'b1, 1'b0);
    rx_case(1'b1, 1'b1, 3'h1, pat[1] >> 16, 1'b1, 1'b1);
    done = 1'b1;
    rx_case(1'b1, 1'b1, 3'h2, pat[1], 1'b1, 1'b0);
    done = 1'b0;
    rx_case(1'b1, 1'b0, 3'h2, pat[1] >> 16, 1'b0, 1'b0);
    rx_case(1'b0, 1'b1, 3'h4, pat[0], 1'b1, 1'b0);
  endtask : rx_scenario
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report
  // Main sequence after a three-cycle reset.
  initial begin
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    reset_i = 1'b0;
    reset_scenario();
    load_scenario();
    tx_scenario();
    rx_scenario();
    final_report();
  end
  // Watchdog well beyond the roughly one thousand cycles the tests need.
  initial begin
    #100000;
    mismatches++;
    final_report();
  end
endmodule : testbench
